// File: opfs_top.v
// What this block does
// - table read/write mode picks none, post-increment, post-decrement or pre-increment of pointer.
// - table pointer is 21 bits into program memory; table latch holds 8 bits.
// - fast bit set saves shadows on call, restores on return; clear leaves shadows alone.
// - relative branch offset is signed displacement; call, goto, return use absolute targets.
// - literals of 8, 12 or 20 bits serve as constant data or target address.
// - indexed moves take a 7-bit source offset from the index register; destination is a 12-bit address or a second 7-bit offset.
// - don't-care instruction bits are ignored; code producers should write them as zero.
// - multiply result lands in separate high and low product bytes.
// - access bit 0 uses access RAM ignoring bank; access bit 1 uses bank selector.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "opfs_regs.vh"
module opfs_top #(
	parameter PTR_W = 21,
	parameter MEM_AW = 8
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o
);
	reg [15:0] instr2_q;
	reg [7:0] wacc_q;
	reg [3:0] bank_q;
	reg [20:0] pc_q;
	reg [20:0] stack_q;
	reg [7:0] product_high_byte_q;
	reg [7:0] product_low_byte_q;
	reg [7:0] shadow_wacc_q;
	reg [3:0] shadow_bank_q;
	reg [11:0] eaddr_q;
	reg [11:0] src_addr_q;
	reg [11:0] dst_addr_q;
	reg [11:0] fsr_q [0:2];
	reg [31:0] rdata_d;
	reg hit_d;
	integer i;

	wire [PTR_W-1:0] table_pointer;
	wire [7:0] table_latch_byte;

	// first access cycle: the answer and any read data are prepared here
	wire acc_phase = psel_i && penable_i && !pready_o;
	// the write takes effect only at the edge where pready is seen high
	wire wr_en = psel_i && penable_i && pready_o && pwrite_i;
	wire exec = wr_en && (paddr_i == `OPFS_A_INSTR);
	wire [15:0] iw = pwdata_i[15:0];
	wire [1:0] pointer_access_mode = iw[1:0];
	wire tbl_rd = exec && (iw[15:2] == 14'h0002);
	wire tbl_wr = exec && (iw[15:2] == 14'h0003);
	wire [15:0] mul_res = wacc_q * iw[7:0];
	wire [20:0] pc_next = pc_q + 21'h000002;
	wire [20:0] pc_next2 = pc_q + 21'h000004;
	wire [20:0] abs_target = {instr2_q[11:0], iw[7:0], 1'b0};
	wire [11:0] fsr2 = fsr_q[2];

	// signed word displacement turned into a byte offset
	function [20:0] opfs_sext;
		input [10:0] n;
		begin
			opfs_sext = {{9{n[10]}}, n, 1'b0};
		end
	endfunction

	// access bank splits between low general RAM and the high special area
	function [11:0] opfs_daddr;
		input a;
		input [7:0] f;
		input [3:0] bank;
		begin
			if (a) begin
				opfs_daddr = {bank, f};
			end else if (f < `OPFS_ACCESS_SPLIT) begin
				opfs_daddr = {4'h0, f};
			end else begin
				opfs_daddr = {`OPFS_ACCESS_HIGH, f};
			end
		end
	endfunction

	opfs_tbl #(
		.PTR_W(PTR_W),
		.MEM_AW(MEM_AW)
	) u_tbl (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.ptr_load_i(wr_en && (paddr_i == `OPFS_A_TPTR)),
		.ptr_data_i(pwdata_i[PTR_W-1:0]),
		.lat_load_i(wr_en && (paddr_i == `OPFS_A_TBLLAT)),
		.lat_data_i(pwdata_i[7:0]),
		.rd_i(tbl_rd),
		.wr_i(tbl_wr),
		.mode_i(pointer_access_mode),
		.ptr_o(table_pointer),
		.lat_o(table_latch_byte)
	);

	always @* begin
		rdata_d = 32'h00000000;
		hit_d = 1'b1;
		case (paddr_i)
			`OPFS_A_INSTR: rdata_d = 32'h00000000;
			`OPFS_A_INSTR2: rdata_d = {16'h0000, instr2_q};
			`OPFS_A_TPTR: rdata_d = {{(32-PTR_W){1'b0}}, table_pointer};
			`OPFS_A_TBLLAT: rdata_d = {24'h000000, table_latch_byte};
			`OPFS_A_PROD: rdata_d = {16'h0000, product_high_byte_q, product_low_byte_q};
			`OPFS_A_WACC: rdata_d = {24'h000000, wacc_q};
			`OPFS_A_BANK: rdata_d = {28'h0000000, bank_q};
			`OPFS_A_PC: rdata_d = {11'h000, pc_q};
			`OPFS_A_EADDR: rdata_d = {4'h0, dst_addr_q, 4'h0, src_addr_q};
			`OPFS_A_SHADOW: rdata_d = {20'h00000, shadow_bank_q, shadow_wacc_q};
			`OPFS_A_STACK: rdata_d = {11'h000, stack_q};
			`OPFS_A_FSR0: rdata_d = {20'h00000, fsr_q[0]};
			`OPFS_A_FSR1: rdata_d = {20'h00000, fsr_q[1]};
			`OPFS_A_FSR2: rdata_d = {4'h0, eaddr_q, 4'h0, fsr2};
			default: hit_d = 1'b0;
		endcase
	end

	// apb slave: one wait state, error on unmapped offsets
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
		end else begin
			pready_o <= acc_phase;
			pslverr_o <= acc_phase && !hit_d;
			if (acc_phase && !pwrite_i) begin
				prdata_o <= rdata_d;
			end
		end
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			instr2_q <= 16'h0000;
			wacc_q <= `OPFS_RST_BYTE;
			bank_q <= `OPFS_RST_BANK;
			pc_q <= `OPFS_RST_PC;
			stack_q <= `OPFS_RST_PC;
			product_high_byte_q <= `OPFS_RST_BYTE;
			product_low_byte_q <= `OPFS_RST_BYTE;
			shadow_wacc_q <= `OPFS_RST_BYTE;
			shadow_bank_q <= `OPFS_RST_BANK;
			eaddr_q <= `OPFS_RST_ADDR;
			src_addr_q <= `OPFS_RST_ADDR;
			dst_addr_q <= `OPFS_RST_ADDR;
			for (i = 0; i < 3; i = i + 1) begin
				fsr_q[i] <= `OPFS_RST_ADDR;
			end
		end else if (wr_en) begin
			case (paddr_i)
				`OPFS_A_INSTR2: instr2_q <= pwdata_i[15:0];
				`OPFS_A_WACC: wacc_q <= pwdata_i[7:0];
				`OPFS_A_BANK: bank_q <= pwdata_i[3:0];
				`OPFS_A_PC: pc_q <= pwdata_i[20:0];
				`OPFS_A_FSR0: fsr_q[0] <= pwdata_i[11:0];
				`OPFS_A_FSR1: fsr_q[1] <= pwdata_i[11:0];
				`OPFS_A_FSR2: fsr_q[2] <= pwdata_i[11:0];
				`OPFS_A_INSTR: begin
					pc_q <= pc_next;
					// unlisted bit positions are '?' so their value never matters
					casez (iw)
						16'b1101_0???_????_????: begin
							pc_q <= pc_next + opfs_sext(iw[10:0]);
						end
						16'b1101_1???_????_????: begin
							stack_q <= pc_next;
							pc_q <= pc_next + opfs_sext(iw[10:0]);
						end
						16'b1110_110?_????_????: begin
							stack_q <= pc_next2;
							pc_q <= abs_target;
							if (iw[8]) begin
								shadow_wacc_q <= wacc_q;
								shadow_bank_q <= bank_q;
							end
						end
						16'b1110_1111_????_????: begin
							pc_q <= abs_target;
						end
						16'b0000_0000_0001_001?: begin
							pc_q <= stack_q;
							if (iw[0]) begin
								wacc_q <= shadow_wacc_q;
								bank_q <= shadow_bank_q;
							end
						end
						16'b0000_1110_????_????: begin
							wacc_q <= iw[7:0];
						end
						16'b0000_1101_????_????: begin
							product_high_byte_q <= mul_res[`OPFS_F_PHI_MSB:`OPFS_F_PHI_LSB];
							product_low_byte_q <= mul_res[7:0];
						end
						16'b0000_0001_????_????: begin
							bank_q <= iw[3:0];
						end
						16'b1110_1110_00??_????: begin
							pc_q <= pc_next2;
							if (iw[5:4] != 2'b11) begin
								fsr_q[iw[5:4]] <= {iw[3:0], instr2_q[7:0]};
							end
						end
						16'b1110_1011_0???_????: begin
							pc_q <= pc_next2;
							src_addr_q <= fsr2 + {5'h00, iw[6:0]};
							dst_addr_q <= instr2_q[11:0];
						end
						16'b1110_1011_1???_????: begin
							pc_q <= pc_next2;
							src_addr_q <= fsr2 + {5'h00, iw[6:0]};
							dst_addr_q <= fsr2 + {5'h00, instr2_q[6:0]};
						end
						16'b0000_001?_????_????,
						16'b0001_????_????_????,
						16'b0010_????_????_????,
						16'b0011_????_????_????,
						16'b0100_????_????_????,
						16'b0101_????_????_????,
						16'b0110_????_????_????,
						16'b10??_????_????_????: begin
							eaddr_q <= opfs_daddr(iw[8], iw[7:0], bank_q);
						end
						default: begin
							pc_q <= pc_next;
						end
					endcase
				end
				default: begin
					pc_q <= pc_q;
				end
			endcase
		end
	end
endmodule

// File: opfs_regs.vh
`ifndef OPFS_REGS_VH
`define OPFS_REGS_VH

// register byte offsets (apb, 32-bit aligned words)
`define OPFS_A_INSTR 8'h00
`define OPFS_A_INSTR2 8'h04
`define OPFS_A_TPTR 8'h08
`define OPFS_A_TBLLAT 8'h0C
`define OPFS_A_PROD 8'h10
`define OPFS_A_WACC 8'h14
`define OPFS_A_BANK 8'h18
`define OPFS_A_PC 8'h1C
`define OPFS_A_EADDR 8'h20
`define OPFS_A_SHADOW 8'h24
`define OPFS_A_STACK 8'h28
`define OPFS_A_FSR0 8'h2C
`define OPFS_A_FSR1 8'h30
`define OPFS_A_FSR2 8'h34

// field positions
`define OPFS_F_PHI_MSB 15
`define OPFS_F_PHI_LSB 8
`define OPFS_F_SRC_LSB 0
`define OPFS_F_DST_LSB 16

// pointer access modes
`define OPFS_MODE_KEEP 2'b00
`define OPFS_MODE_POSTINC 2'b01
`define OPFS_MODE_POSTDEC 2'b10
`define OPFS_MODE_PREINC 2'b11

// reset values
`define OPFS_RST_PTR 21'h000000
`define OPFS_RST_PC 21'h000000
`define OPFS_RST_BYTE 8'h00
`define OPFS_RST_BANK 4'h0
`define OPFS_RST_ADDR 12'h000

// lowest access-bank address that maps to the upper special-function area
`define OPFS_ACCESS_SPLIT 8'h60
`define OPFS_ACCESS_HIGH 4'hF

// timing: slave answers one cycle into the access phase
`define OPFS_WAIT_CYCLES 1

`endif

// File: opfs_tbl.v
`timescale 1ns/100ps
module opfs_tbl #(
	parameter PTR_W = 21,
	parameter MEM_AW = 8
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire ptr_load_i,
	input wire [PTR_W-1:0] ptr_data_i,
	input wire lat_load_i,
	input wire [7:0] lat_data_i,
	input wire rd_i,
	input wire wr_i,
	input wire [1:0] mode_i,
	output reg [PTR_W-1:0] ptr_o,
	output reg [7:0] lat_o
);
	localparam [PTR_W-1:0] ONE = {{(PTR_W-1){1'b0}}, 1'b1};
	reg [7:0] mem_q [0:(1<<MEM_AW)-1];
	wire [PTR_W-1:0] ptr_inc = ptr_o + ONE;
	wire [PTR_W-1:0] ptr_dec = ptr_o - ONE;
	// pre-increment moves first and then touches the new location
	wire [PTR_W-1:0] acc_addr = (mode_i == `OPFS_MODE_PREINC) ? ptr_inc : ptr_o;
	wire [MEM_AW-1:0] mem_idx = acc_addr[MEM_AW-1:0];

	// program memory image is modelled only in its low MEM_AW address bits
	always @(posedge core_clk_i) begin
		if (wr_i) begin
			mem_q[mem_idx] <= lat_o;
		end
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			ptr_o <= `OPFS_RST_PTR;
			lat_o <= `OPFS_RST_BYTE;
		end else begin
			if (rd_i) begin
				lat_o <= mem_q[mem_idx];
			end else if (lat_load_i) begin
				lat_o <= lat_data_i;
			end
			if (rd_i || wr_i) begin
				case (mode_i)
					`OPFS_MODE_KEEP: ptr_o <= ptr_o;
					`OPFS_MODE_POSTINC: ptr_o <= ptr_inc;
					`OPFS_MODE_POSTDEC: ptr_o <= ptr_dec;
					`OPFS_MODE_PREINC: ptr_o <= ptr_inc;
					default: ptr_o <= ptr_o;
				endcase
			end else if (ptr_load_i) begin
				ptr_o <= ptr_data_i;
			end
		end
	end
endmodule

// File: opfs_top_monitor.sv
`timescale 1ns/100ps
module opfs_top_chk (
	input wire core_clk_i,
	input wire rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	wire rd = pready_o && !pwrite_i;
	ready_wait_a: assert property ($rose(penable_i) && psel_i |=> pready_o) else $error("ready late");
	ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
	err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
	ptr_width_a: assert property (rd && paddr_i == 8'h08 |-> prdata_o[31:21] == 11'h0) else $error("ptr wide");
	latch_width_a: assert property (rd && paddr_i == 8'h0C |-> prdata_o[31:8] == 24'h0) else $error("latch wide");
	prod_split_a: assert property (rd && paddr_i == 8'h10 |-> prdata_o[31:16] == 16'h0) else $error("prod wide");
	lit_width_a: assert property (rd && paddr_i == 8'h14 |-> prdata_o[31:8] == 24'h0) else $error("acc wide");
	idx_width_a: assert property (rd && paddr_i == 8'h20 |-> prdata_o[15:12] == 4'h0) else $error("idx wide");
	cover property (rd && paddr_i == 8'h10);
	cover property (pslverr_o);
	cover property (pready_o && pwrite_i && paddr_i == 8'h00);
endmodule
bind opfs_top opfs_top_chk chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

// File: opfs_fetch_model.sv
`timescale 1ns/100ps
module opfs_fetch_model (
	input wire core_clk_i,
	input wire pready_i,
	input wire pslverr_i,
	input wire [31:0] prdata_i,
	output reg psel_o,
	output reg penable_o,
	output reg pwrite_o,
	output reg [7:0] paddr_o,
	output reg [31:0] pwdata_o
);
	initial begin
		{psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = 43'h0;
	end
	// idle cycle after each transfer keeps psel from being assigned twice in one step
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		begin
			psel_o <= 1'h1;
			pwrite_o <= wr;
			paddr_o <= a;
			pwdata_o <= d;
			@(posedge core_clk_i);
			penable_o <= 1'h1;
			@(posedge core_clk_i);
			while (pready_i !== 1'h1) @(posedge core_clk_i);
			r = prdata_i;
			e = pslverr_i;
			psel_o <= 1'h0;
			penable_o <= 1'h0;
			pwdata_o <= ~d;
			@(posedge core_clk_i);
		end
	endtask
endmodule

// File: tb_opfs_top.sv
`timescale 1ns/100ps
module tb_opfs_top;
	logic core_clk_i = 1'h0;
	logic rst_i = 1'h1;
	wire psel, pen, pwr, rdy, err;
	wire [7:0] addr;
	wire [31:0] wd, rdat;
	int errors = 0;
	int checks_done = 0;
	always #5 core_clk_i = ~core_clk_i;
	opfs_top dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(addr), .pwdata_i(wd), .prdata_o(rdat), .pready_o(rdy), .pslverr_o(err));
	opfs_fetch_model m_u (.core_clk_i(core_clk_i), .pready_i(rdy), .pslverr_i(err), .prdata_i(rdat),
		.psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(addr), .pwdata_o(wd));
	task conclude;
		begin
			$display("checks %0d errors %0d", checks_done, errors);
			if (errors == 0 && checks_done > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task check(input string n, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask
	task w(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		m_u.xfer(1'h1, a, d, r, e);
	endtask
	task c(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		m_u.xfer(1'h0, a, 32'h0, r, e);
		check($sformatf("reg %h", a), r, exp);
	endtask
	task t_table;
		w(8'h08, 32'h001FFFFF);
		w(8'h0C, 32'h000000A5);
		w(8'h00, 32'h0000000D);
		c(8'h08, 32'h00000000);
		w(8'h0C, 32'h0000003C);
		w(8'h00, 32'h0000000E);
		c(8'h08, 32'h001FFFFF);
		w(8'h00, 32'h00000008);
		c(8'h0C, 32'h000000A5);
		c(8'h08, 32'h001FFFFF);
		w(8'h00, 32'h0000000B);
		c(8'h0C, 32'h0000003C);
		c(8'h08, 32'h00000000);
		$display("table modes done");
	endtask
	task t_mul;
		w(8'h00, 32'h00000EF3);
		c(8'h14, 32'h000000F3);
		w(8'h00, 32'h00000D11);
		c(8'h10, 32'h00001023);
		w(8'h00, 32'h000001F5);
		c(8'h18, 32'h00000005);
		$display("multiply done");
	endtask
	task t_call;
		w(8'h14, 32'h0000005A);
		w(8'h18, 32'h00000003);
		w(8'h1C, 32'h00000100);
		w(8'h04, 32'h0000F000);
		w(8'h00, 32'h0000ED40);
		c(8'h1C, 32'h00000080);
		c(8'h28, 32'h00000104);
		c(8'h24, 32'h0000035A);
		w(8'h14, 32'h00000000);
		w(8'h18, 32'h00000000);
		w(8'h00, 32'h0000EC40);
		c(8'h24, 32'h0000035A);
		w(8'h00, 32'h00000013);
		c(8'h1C, 32'h00000084);
		c(8'h14, 32'h0000005A);
		c(8'h18, 32'h00000003);
		w(8'h1C, 32'h00000200);
		w(8'h00, 32'h0000D7FE);
		c(8'h1C, 32'h000001FE);
		w(8'h04, 32'h0000F123);
		w(8'h00, 32'h0000EF45);
		c(8'h1C, 32'h0002468A);
		w(8'h00, 32'h0000D801);
		c(8'h1C, 32'h0002468E);
		c(8'h28, 32'h0002468C);
		$display("call branch done");
	endtask
	task t_addr;
		logic [31:0] r;
		logic e;
		w(8'h34, 32'h00000000);
		w(8'h00, 32'h00006F20);
		c(8'h34, 32'h03200000);
		w(8'h00, 32'h00006E80);
		c(8'h34, 32'h0F800000);
		w(8'h34, 32'h00000100);
		w(8'h04, 32'h0000FFFF);
		w(8'h00, 32'h0000EB85);
		c(8'h20, 32'h017F0105);
		w(8'h00, 32'h00006E20);
		c(8'h34, 32'h00200100);
		w(8'h04, 32'h00000ABC);
		w(8'h00, 32'h0000EB03);
		c(8'h20, 32'h0ABC0103);
		w(8'h04, 32'h000000AB);
		w(8'h00, 32'h0000EE15);
		c(8'h30, 32'h000005AB);
		m_u.xfer(1'h0, 8'h3C, 32'h0, r, e);
		check("unmapped", {r[31:1], e}, 32'h00000001);
		$display("addressing done");
	endtask
	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'h0;
		@(posedge core_clk_i);
		t_table;
		t_mul;
		t_call;
		t_addr;
		conclude;
	end
	initial begin
		#40000;
		errors++;
		conclude;
	end
endmodule
